// File: rtc_pkg.sv
// Package of constants and carriers for the reload timer counter
package rtc_pkg;

	// =====================================================
	// Register map (byte addresses, word index = byte address / 4)
	// =====================================================
	localparam logic [3:0] RTC_ADDR_CTRL = 4'h0;
	localparam logic [3:0] RTC_ADDR_COUNT = 4'h4;
	localparam logic [3:0] RTC_ADDR_RELOAD = 4'h8;
	localparam logic [3:0] RTC_ADDR_STATUS = 4'hC;
	localparam int RTC_TIMER_STRIDE = 16;
	localparam int RTC_ADDR_W = 5;

	// =====================================================
	// Control field positions
	// =====================================================
	localparam int RTC_CTRL_EN = 0;
	localparam int RTC_CTRL_POL = 1;
	localparam int RTC_CTRL_OUTEN = 2;
	localparam int RTC_CTRL_MODE_LO = 3;
	localparam int RTC_CTRL_PRE_LO = 5;
	localparam int RTC_CTRL_W = 8;

	// =====================================================
	// Reset values and counts
	// =====================================================
	localparam logic [15:0] RTC_COUNT_RST = 16'h0001;
	localparam logic [15:0] RTC_RELOAD_RST = 16'h0000;
	localparam logic [15:0] RTC_COUNT_ONE = 16'h0001;
	localparam logic [15:0] RTC_COUNT_ONES = 16'hFFFF;
	localparam logic [15:0] RTC_COUNT_ZERO = 16'h0000;
	localparam logic [6:0] RTC_PRE_MAX = 7'h7F;

	// Operating modes
	typedef enum logic [1:0] {
		RTC_ONE_SHOT,
		RTC_CONTINUOUS,
		RTC_COUNTER,
		RTC_CMP_COUNTER
	} rtc_mode_type;

	// Software control word
	typedef struct packed {
		logic [2:0] prescale_sel;
		rtc_mode_type mode;
		logic out_enable;
		logic output_polarity_bit;
		logic enable;
	} rtc_ctrl_type;

	// Register bus request
	typedef struct packed {
		logic [RTC_ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} rtc_bus_type;

	// Timer state
	typedef struct packed {
		rtc_ctrl_type ctrl;
		logic [15:0] count;
		logic [15:0] reload;
		logic [6:0] pre_cnt;
		logic out_level;
		logic pulse;
		logic irq;
		logic reload_seen;
		logic [2:0] ext_sync;
		logic [2:0] cmp_sync;
		logic [31:0] rdata;
		logic rd_hit;
	} rtc_timer_state_type;

	// Top state
	typedef struct packed {
		logic [31:0] rdata;
	} rtc_top_state_type;

endpackage : rtc_pkg

// File: rtc_timer.sv
// One 16-bit reloadable timer channel
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/10ps
module rtc_timer
	import rtc_pkg::*;
(
	input wire logic ref_clk, // System clock
	input wire logic srst, // Synchronous reset
	input wire logic sel, // Bus access targets this channel
	input wire logic [3:0] reg_addr, // Offset within channel
	input wire logic [31:0] wdata, // Write data
	input wire logic wr, // Write strobe
	input wire logic rd, // Read strobe
	input wire logic ext_in, // Timer input pin, asynchronous
	input wire logic cmp_in, // Comparator output, asynchronous
	output logic [31:0] rdata, // Read data, valid with rd_hit
	output logic rd_hit, // Read data valid
	output logic timer_out, // Timer output pin
	output logic irq // Reload event pulse
);

	rtc_timer_state_type st;
	rtc_timer_state_type next_st;

	logic ext_edge;
	logic cmp_edge;
	logic pre_tick;
	logic tick;
	logic at_reload;
	logic [6:0] pre_div;

	// =====================================================
	// Edge detection and count source
	// =====================================================
	always_comb begin
		// Bits 1 and 2 are past the first synchroniser stage
		ext_edge = st.ctrl.output_polarity_bit ?
			(st.ext_sync[1] & ~st.ext_sync[2]) :
			(~st.ext_sync[1] & st.ext_sync[2]);
		cmp_edge = st.ctrl.output_polarity_bit ?
			(st.cmp_sync[1] & ~st.cmp_sync[2]) :
			(~st.cmp_sync[1] & st.cmp_sync[2]);
		pre_div = 7'((8'h01 << st.ctrl.prescale_sel) - 8'h01);
		pre_tick = (st.pre_cnt >= pre_div);
		case (st.ctrl.mode)
			RTC_ONE_SHOT,
			RTC_CONTINUOUS: tick = pre_tick;
			RTC_COUNTER: tick = ext_edge;
			default: tick = cmp_edge;
		endcase
		at_reload = (st.count == st.reload);
	end

	// =====================================================
	// Next state
	// =====================================================
	always_comb begin
		next_st = st;
		next_st.ext_sync = {st.ext_sync[1:0], ext_in};
		next_st.cmp_sync = {st.cmp_sync[1:0], cmp_in};
		next_st.irq = 1'b0;
		next_st.rd_hit = 1'b0;
		next_st.reload_seen = 1'b0;
		if (st.pulse) begin
			next_st.pulse = 1'b0;
			next_st.out_level = ~st.out_level;
		end
		if (st.ctrl.enable) begin
			if (st.ctrl.mode == RTC_ONE_SHOT ||
				st.ctrl.mode == RTC_CONTINUOUS) begin
				next_st.pre_cnt = pre_tick ? 7'h00 :
					7'(st.pre_cnt + 7'h01);
			end
			if (tick) begin
				if (at_reload) begin
					next_st.count = RTC_COUNT_ONE;
					next_st.irq = 1'b1;
					next_st.reload_seen = 1'b1;
					if (st.ctrl.mode == RTC_ONE_SHOT) begin
						next_st.ctrl.enable = 1'b0;
						if (st.ctrl.out_enable) begin
							next_st.out_level = ~st.out_level;
							next_st.pulse = 1'b1;
						end
					end else if (st.ctrl.out_enable) begin
						next_st.out_level = ~st.out_level;
					end
				end else begin
					// Wraps FFFF to 0000 naturally
					next_st.count = 16'(st.count + 16'h0001);
				end
			end
		end
		// Register reads
		if (sel && rd) begin
			next_st.rd_hit = 1'b1;
			if (reg_addr == RTC_ADDR_CTRL) begin
				next_st.rdata = {24'h000000, st.ctrl};
			end else if (reg_addr == RTC_ADDR_COUNT) begin
				next_st.rdata = {16'h0000, st.count};
			end else if (reg_addr == RTC_ADDR_RELOAD) begin
				next_st.rdata = {16'h0000, st.reload};
			end else if (reg_addr == RTC_ADDR_STATUS) begin
				next_st.rdata = {30'h00000000, st.out_level, st.ctrl.enable};
			end else begin
				next_st.rdata = 32'h00000000;
			end
		end
		// Register writes; count and reload accepted whether running or stopped
		if (sel && wr) begin
			if (reg_addr == RTC_ADDR_CTRL) begin
				next_st.ctrl = rtc_ctrl_type'(wdata[RTC_CTRL_W-1:0]);
				if (!wdata[RTC_CTRL_EN]) begin
					// Polarity sets starting output level
					next_st.out_level = wdata[RTC_CTRL_POL];
					next_st.pulse = 1'b0;
				end
				next_st.pre_cnt = 7'h00;
			end else if (reg_addr == RTC_ADDR_COUNT) begin
				next_st.count = wdata[15:0];
			end else if (reg_addr == RTC_ADDR_RELOAD) begin
				next_st.reload = wdata[15:0];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st <= '0;
			st.count <= RTC_COUNT_RST;
			st.reload <= RTC_RELOAD_RST;
		end else begin
			st <= next_st;
		end
	end

	assign rdata = st.rdata;
	assign rd_hit = st.rd_hit;
	assign timer_out = st.out_level;
	assign irq = st.irq;

endmodule : rtc_timer

// File: rtc_top.sv
// Dual 16-bit reload timer counter with register port
`timescale 1ns/10ps
module rtc_top
	import rtc_pkg::*;
#(
	parameter int NUM_TIMERS = 2 // Timer channels, 1 or 2
)(
	input wire logic ref_clk, // 40 MHz system clock
	input wire logic srst, // Synchronous reset, active high
	input wire logic [RTC_ADDR_W-1:0] addr, // Register byte address
	input wire logic [31:0] wdata, // Write data
	input wire logic wr, // Write strobe
	input wire logic rd, // Read strobe
	output logic [31:0] rdata, // Read data, cycle after rd
	input wire logic [NUM_TIMERS-1:0] ext_in, // Timer input pins
	input wire logic cmp_in, // Analog comparator output
	output logic [NUM_TIMERS-1:0] timer_out, // Timer output pins
	output logic [NUM_TIMERS-1:0] irq // Reload interrupt pulses
);

	logic [31:0] ch_rdata [NUM_TIMERS];
	logic [NUM_TIMERS-1:0] ch_hit;

	// =====================================================
	// Timer channels
	// =====================================================
	genvar gi;
	generate
		for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_ch
			rtc_timer u_timer (
				.ref_clk(ref_clk),
				.srst(srst),
				.sel(int'(addr[RTC_ADDR_W-1]) == gi),
				.reg_addr(addr[3:0]),
				.wdata(wdata),
				.wr(wr),
				.rd(rd),
				.ext_in(ext_in[gi]),
				.cmp_in(cmp_in),
				.rdata(ch_rdata[gi]),
				.rd_hit(ch_hit[gi]),
				.timer_out(timer_out[gi]),
				.irq(irq[gi])
			);
		end
	endgenerate

	// =====================================================
	// Read data merge; unmapped reads return zero
	// =====================================================
	always_comb begin
		rdata = 32'h00000000;
		for (int i = 0; i < NUM_TIMERS; i++) begin
			if (ch_hit[i]) begin
				rdata = ch_rdata[i];
			end
		end
	end

endmodule : rtc_top

// File: rtc_asserts.sv
// Port checker for the reload timer counter
`timescale 1ns/10ps
module rtc_asserts
	import rtc_pkg::*;
#(
	parameter int NUM_TIMERS = 2 // Timer channels
)(
	input wire logic ref_clk, // Clock
	input wire logic srst, // Reset
	input wire logic [RTC_ADDR_W-1:0] addr, // Address
	input wire logic [31:0] wdata, // Write data
	input wire logic wr, // Write strobe
	input wire logic rd, // Read strobe
	input wire logic [31:0] rdata, // Read data
	input wire logic [NUM_TIMERS-1:0] ext_in, // Input pins
	input wire logic cmp_in, // Comparator
	input wire logic [NUM_TIMERS-1:0] timer_out, // Output pins
	input wire logic [NUM_TIMERS-1:0] irq // Interrupts
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// ====
	// Register port
	sequence s_rd(logic [3:0] o);
		rd && addr[3:0] == o;
	endsequence
	a_idle_rdata_zero: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("rdata not zero outside read");
	a_unmapped_zero: assert property (rd && addr[1:0] != 2'h0 |=> rdata == 0)
		else $error("unmapped read not zero");
	a_count_width: assert property (s_rd(4'h4) |=> rdata[31:16] == 16'h0)
		else $error("count wider than 16 bits");
	a_reload_width: assert property (s_rd(4'h8) |=> rdata[31:16] == 16'h0)
		else $error("reload wider than 16 bits");
	a_status_width: assert property (s_rd(4'hC) |=> rdata[31:2] == 30'h0)
		else $error("status spare bits set");
	// ====
	// Timer pins
	a_irq_one_cycle: assert property (irq[0] |=> !irq[0])
		else $error("interrupt pulse too long");
	a_out_hold: assert property ($changed(timer_out) |->
		(irq != '0 || $past(irq) != '0 || $past(wr) || $past(wr, 2))
		or ##1 irq != '0) else $error("output moved without cause");
	a_reset_clear: assert property ($fell(srst) |-> irq == '0 && timer_out == '0)
		else $error("outputs not cleared by reset");
endmodule : rtc_asserts
bind rtc_top rtc_asserts #(.NUM_TIMERS(NUM_TIMERS)) rtc_asserts_inst (
	.ref_clk(ref_clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
	.rd(rd), .rdata(rdata), .ext_in(ext_in), .cmp_in(cmp_in),
	.timer_out(timer_out), .irq(irq));

// File: rtc_pins.sv
// Pulse source for a timer input pin or comparator output
`timescale 1ns/10ps
module rtc_pins (
	input wire logic ref_clk, // System clock
	input wire logic run, // Pulses while high
	output logic pin // Pulse train, low when idle
);
	logic [2:0] ph = 3'h0;
	// Eight-cycle period stays under a quarter clock
	always @(posedge ref_clk) ph <= run ? ph + 3'h1 : 3'h0;
	assign pin = ph[2];
endmodule : rtc_pins

// File: rtc_top_test.sv
// Self-checking bench for the reload timer counter
`timescale 1ns/10ps
module rtc_top_test;
	import rtc_pkg::*;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic [RTC_ADDR_W-1:0] addr = '0;
	logic [31:0] wdata = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic ext_run = 1'b0;
	logic cmp_run = 1'b0;
	logic [31:0] rdata;
	logic ext_pin;
	logic cmp_pin;
	logic [1:0] timer_out;
	logic [1:0] irq;
	logic lvl;
	int failures = 0;
	int n_checks = 0;
	int n;
	always #12.5 ref_clk = ~ref_clk;
	rtc_top rtc_top_inst (.ref_clk(ref_clk), .srst(srst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.ext_in({ext_pin, 1'b0}), .cmp_in(cmp_pin),
		.timer_out(timer_out), .irq(irq));
	rtc_pins rtc_pins_inst (.ref_clk(ref_clk), .run(ext_run), .pin(ext_pin));
	rtc_pins rtc_pins_cmp_inst (.ref_clk(ref_clk), .run(cmp_run),
		.pin(cmp_pin));
	// ====
	// Tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask : rd_chk
	task automatic wait_irq(output int c);
		c = 0;
		do begin
			@(posedge ref_clk);
			#1;
			c++;
		end while (irq[0] !== 1'b1 && c < 2000);
	endtask : wait_irq
	task automatic pulses(input logic e, input logic c);
		@(posedge ref_clk);
		ext_run <= e;
		cmp_run <= c;
		repeat (40) @(posedge ref_clk);
		ext_run <= 1'b0;
		cmp_run <= 1'b0;
		repeat (8) @(posedge ref_clk);
	endtask : pulses
	task automatic finish_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : finish_test
	// ====
	// Tests
	initial begin
		repeat (20) @(posedge ref_clk);
		srst <= 1'b0;
		rd_chk(5'h04, 32'h1);
		rd_chk(5'h18, 32'h0);
		rd_chk(5'h05, 32'h0);
		wr_reg(5'h00, 32'h04);
		wr_reg(5'h04, 32'hFFFE);
		wr_reg(5'h08, 32'h0002);
		wr_reg(5'h00, 32'h05);
		wait_irq(n);
		chk({31'h0, irq[0]}, 32'h1);
		chk({31'h0, timer_out[0]}, 32'h1);
		rd_chk(5'h04, 32'h1);
		rd_chk(5'h0C, 32'h0);
		rd_chk(5'h04, 32'h1);
		wr_reg(5'h00, 32'h4C);
		wr_reg(5'h04, 32'h3);
		wr_reg(5'h08, 32'h5);
		wr_reg(5'h00, 32'h4D);
		wait_irq(n);
		wait_irq(n);
		chk(n, 32'd20);
		repeat (3) @(posedge ref_clk);
		#1;
		lvl = timer_out[0];
		wait_irq(n);
		chk(n, 32'd17);
		repeat (3) @(posedge ref_clk);
		#1;
		chk({31'h0, timer_out[0]}, {31'h0, ~lvl});
		wr_reg(5'h10, 32'h12);
		rd_chk(5'h1C, 32'h2);
		wr_reg(5'h14, 32'h1);
		wr_reg(5'h18, 32'h10);
		wr_reg(5'h10, 32'h13);
		pulses(1'b1, 1'b0);
		rd_chk(5'h14, 32'h6);
		wr_reg(5'h00, 32'h1A);
		wr_reg(5'h04, 32'h1);
		wr_reg(5'h08, 32'h3);
		wr_reg(5'h00, 32'h1B);
		pulses(1'b0, 1'b1);
		rd_chk(5'h04, 32'h3);
		finish_test;
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		failures++;
		finish_test;
	end
endmodule : rtc_top_test
